// ---- hdl/bteu_core.sv ----
// bit, flag, transfer and machine control execution unit
`timescale 1ns/10ps
module bteu_core (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  // instruction
  input  wire logic                  start_i,
  input  wire bteu_pkg::bteu_op_t    op_i,
  input  wire bteu_pkg::bteu_amode_t mode_i,
  input  wire bteu_pkg::bteu_ptr_t   ptr_i,
  input  wire logic [4:0]            rd_i,
  input  wire logic [4:0]            rr_i,
  input  wire logic [2:0]            bit_i,
  input  wire logic [7:0]            imm_i,
  input  wire logic [15:0]           addr_i,
  input  wire logic [5:0]            io_addr_i,
  input  wire logic                  debug_en_i,
  input  wire logic [4:0]            peek_idx_i,
  // status
  output logic                       busy_o,
  output logic                       done_o,
  output logic [7:0]                 flags_o,
  output logic [15:0]                sp_o,
  output logic [7:0]                 peek_data_o,
  // data memory
  output logic [15:0]                dm_addr_o,
  output logic [7:0]                 dm_wdata_o,
  output logic                       dm_we_o,
  output logic                       dm_re_o,
  input  wire logic [7:0]            dm_rdata_i,
  // program memory
  output logic [15:0]                pm_addr_o,
  output logic                       pm_re_o,
  input  wire logic [7:0]            pm_rdata_i,
  // io space
  input  wire logic [7:0]            io_rd_data_i,
  output logic [5:0]                 io_addr_o,
  output logic [7:0]                 io_wdata_o,
  output logic                       io_we_o,
  // machine control
  output logic                       sleep_o,
  output logic                       wdt_kick_o,
  output logic                       break_o
);
  import bteu_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_PM, S_FIN} bteu_state_t;

  // ============================================================
  // state
  logic [7:0]  regs_q [32];
  logic [7:0]  flags_q, flags_d;
  logic [15:0] sp_q;
  bteu_state_t st_q, st_d;
  logic        ld_pend_q, ld_pm_q;
  logic [4:0]  ld_idx_q;
  logic [15:0] dm_addr_q, pm_addr_q;
  logic [7:0]  dm_wdata_q, io_wdata_q, peek_q;
  logic [5:0]  io_addr_q;
  logic        dm_we_q, dm_re_q, pm_re_q, io_we_q;
  logic        sleep_q, kick_q, brk_q, done_q, busy_q;

  // ============================================================
  // operand decode
  wire         go_w    = start_i && (st_q == S_IDLE);
  wire [7:0]   rd_v_w  = regs_q[rd_i];
  wire [7:0]   rr_v_w  = regs_q[rr_i];
  wire [7:0]   mask_w  = ONE8 << bit_i;
  wire [3:0]   pair_w  = (ptr_i == BTEU_PTR_X) ? PAIR_X :
                         (ptr_i == BTEU_PTR_Y) ? PAIR_Y : PAIR_Z;
  wire [15:0]  ptr_w   = {regs_q[{pair_w, 1'b1}], regs_q[{pair_w, 1'b0}]};
  wire [15:0]  z_w     = {regs_q[{PAIR_Z, 1'b1}], regs_q[{PAIR_Z, 1'b0}]};
  wire [15:0]  inc_w   = ptr_w + ONE16;
  wire [15:0]  dec_w   = ptr_w - ONE16;
  wire [15:0]  disp_w  = ptr_w + {8'h00, imm_i};
  wire [15:0]  sp_up_w = sp_q + ONE16;
  wire         is_sh_w = (op_i == BTEU_SHL) || (op_i == BTEU_SHR) ||
                         (op_i == BTEU_SAR) || (op_i == BTEU_RCL) ||
                         (op_i == BTEU_RCR);
  wire         is_pmr_w = (op_i == BTEU_PMR) || (op_i == BTEU_PMR0);

  // effective indirect address: pre-decrement uses the lowered pointer
  wire [15:0]  eff_w   = (mode_i == BTEU_AM_PREDEC) ? dec_w :
                         (mode_i == BTEU_AM_DISP)   ? disp_w :
                         ptr_w;

  // ============================================================
  // shift unit
  logic [7:0] sh_dout_w;
  logic       sh_c_w, sh_z_w, sh_n_w, sh_v_w;

  bteu_shift u_shift (
    .op_i   (op_i),
    .din_i  (rd_v_w),
    .cin_i  (flags_q[FLG_C]),
    .dout_o (sh_dout_w),
    .cout_o (sh_c_w),
    .z_o    (sh_z_w),
    .n_o    (sh_n_w),
    .v_o    (sh_v_w)
  );

  // ============================================================
  // single register write port: one-cycle results or a finishing load
  wire fin_ld_w = (st_q == S_FIN) && ld_pend_q;
  wire wr_en_w  = fin_ld_w || (go_w && (is_sh_w ||
                  (op_i == BTEU_SWAP) || (op_i == BTEU_TLDB) ||
                  (op_i == BTEU_MOV) || (op_i == BTEU_LDK) ||
                  (op_i == BTEU_IN)));
  wire [4:0] wr_idx_w = fin_ld_w ? ld_idx_q : rd_i;
  wire [7:0] tldb_w   = flags_q[FLG_T] ? (rd_v_w | mask_w)
                                       : (rd_v_w & ~mask_w);
  wire [7:0] wr_dat_w =
    fin_ld_w                  ? (ld_pm_q ? pm_rdata_i : dm_rdata_i) :
    (op_i == BTEU_TLDB)       ? tldb_w :
    (op_i == BTEU_MOV)        ? rr_v_w :
    (op_i == BTEU_LDK)        ? imm_i :
    (op_i == BTEU_IN)         ? io_rd_data_i :
    sh_dout_w;

  // pair write port: word copy or pointer update, written on the start edge of a memory access, the same edge that raises its strobe
  wire ptr_upd_w = go_w && ((op_i == BTEU_LD) || (op_i == BTEU_ST)) &&
                   ((mode_i == BTEU_AM_POSTINC) ||
                    (mode_i == BTEU_AM_PREDEC));
  wire z_upd_w   = go_w && (op_i == BTEU_PMR) &&
                   (mode_i == BTEU_AM_POSTINC);
  wire pw_en_w   = (go_w && (op_i == BTEU_PCPY)) || ptr_upd_w || z_upd_w;
  wire [3:0]  pw_pair_w = z_upd_w ? PAIR_Z :
                          ptr_upd_w ? pair_w : rd_i[4:1];
  wire [15:0] pw_dat_w  =
    z_upd_w ? (z_w + ONE16) :
    ptr_upd_w ? ((mode_i == BTEU_AM_PREDEC) ? dec_w : inc_w) :
    {regs_q[{rr_i[4:1], 1'b1}], regs_q[{rr_i[4:1], 1'b0}]};

  // register file; a load into the pointer, written in the finishing cycle, overrides the pair write
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_w) begin
      regs_q[wr_idx_w] <= wr_dat_w;
    end
    if (pw_en_w) begin
      {regs_q[{pw_pair_w, 1'b1}], regs_q[{pw_pair_w, 1'b0}]} <= pw_dat_w;
    end
  end

  // ============================================================
  // flag update: only shifts, flag ops and bit store touch flags
  always_comb begin
    flags_d = flags_q;
    if (go_w && is_sh_w) begin
      flags_d[FLG_C] = sh_c_w;
      flags_d[FLG_Z] = sh_z_w;
      flags_d[FLG_N] = sh_n_w;
      flags_d[FLG_V] = sh_v_w;
    end else if (go_w && (op_i == BTEU_BSET)) begin
      flags_d[bit_i] = 1'b1;
    end else if (go_w && (op_i == BTEU_BCLR)) begin
      flags_d[bit_i] = 1'b0;
    end else if (go_w && (op_i == BTEU_TSTO)) begin
      flags_d[FLG_T] = rd_v_w[bit_i];
    end
  end

  // ============================================================
  // sequencing: memory and io-bit ops hold for a finishing cycle
  wire two_cyc_w = (op_i == BTEU_IOSET) || (op_i == BTEU_IOCLR) ||
                   (op_i == BTEU_LD) || (op_i == BTEU_ST) ||
                   (op_i == BTEU_LDA) || (op_i == BTEU_STA) ||
                   (op_i == BTEU_PUSH) || (op_i == BTEU_POP);
  wire loads_w   = (op_i == BTEU_LD) || (op_i == BTEU_LDA) ||
                   (op_i == BTEU_POP) || is_pmr_w;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: begin
        if (go_w && is_pmr_w) begin
          st_d = S_PM;
        end else if (go_w && two_cyc_w) begin
          st_d = S_FIN;
        end
      end
      S_PM:  st_d = S_FIN;
      S_FIN: st_d = S_IDLE;
    endcase
  end

  // ============================================================
  // memory and io strobes, one-cycle pulses except the two-cycle pm read strobe; addresses hold
  wire        dm_go_w = go_w && (two_cyc_w && (op_i != BTEU_IOSET) &&
                                 (op_i != BTEU_IOCLR));
  wire [15:0] dm_a_w  = (op_i == BTEU_LDA) || (op_i == BTEU_STA) ?
                        addr_i :
                        (op_i == BTEU_PUSH) ? sp_q :
                        (op_i == BTEU_POP) ? sp_up_w : eff_w;
  wire        dm_wr_w = (op_i == BTEU_ST) || (op_i == BTEU_STA) ||
                        (op_i == BTEU_PUSH);
  wire        io_bit_w = (op_i == BTEU_IOSET) || (op_i == BTEU_IOCLR);
  wire [7:0]  io_mod_w = (op_i == BTEU_IOSET) ? (io_rd_data_i | mask_w)
                                            : (io_rd_data_i & ~mask_w);
  wire        io_go_w  = go_w && (io_bit_w || (op_i == BTEU_OUT));

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dm_addr_q  <= 16'h0000;
      dm_wdata_q <= 8'h00;
      dm_we_q    <= 1'b0;
      dm_re_q    <= 1'b0;
      pm_addr_q  <= 16'h0000;
      pm_re_q    <= 1'b0;
      io_addr_q  <= 6'h00;
      io_wdata_q <= 8'h00;
      io_we_q    <= 1'b0;
    end else begin
      dm_we_q <= dm_go_w && dm_wr_w;
      dm_re_q <= dm_go_w && !dm_wr_w;
      pm_re_q <= (go_w && is_pmr_w) || (st_q == S_PM);
      io_we_q <= io_go_w;
      if (dm_go_w) begin
        dm_addr_q  <= dm_a_w;
        dm_wdata_q <= rd_v_w;
      end
      if (go_w && is_pmr_w) begin
        pm_addr_q <= z_w;
      end
      if (io_go_w) begin
        io_addr_q  <= io_addr_i;
        io_wdata_q <= io_bit_w ? io_mod_w : rd_v_w;
      end
    end
  end

  // ============================================================
  // control state, stack pointer and completion
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q      <= S_IDLE;
      flags_q   <= FLAGS_RST;
      sp_q      <= SP_RST;
      ld_pend_q <= 1'b0;
      ld_pm_q   <= 1'b0;
      ld_idx_q  <= REG_R0;
      done_q    <= 1'b0;
      busy_q    <= 1'b0;
      sleep_q   <= 1'b0;
      kick_q    <= 1'b0;
      brk_q     <= 1'b0;
      peek_q    <= 8'h00;
    end else begin
      st_q    <= st_d;
      flags_q <= flags_d;
      busy_q  <= (st_d != S_IDLE);
      done_q  <= (go_w && !two_cyc_w && !is_pmr_w) || (st_q == S_FIN);
      sleep_q <= go_w && (op_i == BTEU_SLEEP);
      kick_q  <= go_w && (op_i == BTEU_KICK);
      brk_q   <= go_w && (op_i == BTEU_BRK) && debug_en_i;
      peek_q  <= regs_q[peek_idx_i];
      if (go_w && (op_i == BTEU_PUSH)) begin
        sp_q <= sp_q - ONE16;
      end else if (go_w && (op_i == BTEU_POP)) begin
        sp_q <= sp_up_w;
      end
      if (go_w) begin
        ld_pend_q <= loads_w;
        ld_pm_q   <= is_pmr_w;
        ld_idx_q  <= (op_i == BTEU_PMR0) ? REG_R0 : rd_i;
      end else if (st_q == S_FIN) begin
        ld_pend_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // outputs straight from flops
  assign busy_o      = busy_q;
  assign done_o      = done_q;
  assign flags_o     = flags_q;
  assign sp_o        = sp_q;
  assign peek_data_o = peek_q;
  assign dm_addr_o   = dm_addr_q;
  assign dm_wdata_o  = dm_wdata_q;
  assign dm_we_o     = dm_we_q;
  assign dm_re_o     = dm_re_q;
  assign pm_addr_o   = pm_addr_q;
  assign pm_re_o     = pm_re_q;
  assign io_addr_o   = io_addr_q;
  assign io_wdata_o  = io_wdata_q;
  assign io_we_o     = io_we_q;
  assign sleep_o     = sleep_q;
  assign wdt_kick_o  = kick_q;
  assign break_o     = brk_q;
endmodule

// ---- hdl/bteu_pkg.sv ----
// package: operation codes, flag positions and constants of the exec unit
// ============================================================
package bteu_pkg;

  // ============================================================
  // operation codes, already decoded by the fetch stage
  typedef enum logic [4:0] {
    BTEU_NOP, BTEU_SLEEP, BTEU_KICK, BTEU_BRK,
    BTEU_SHL, BTEU_SHR, BTEU_SAR, BTEU_RCL, BTEU_RCR, BTEU_SWAP,
    BTEU_BSET, BTEU_BCLR, BTEU_TSTO, BTEU_TLDB,
    BTEU_MOV, BTEU_PCPY, BTEU_LDK, BTEU_IN, BTEU_OUT,
    BTEU_IOSET, BTEU_IOCLR, BTEU_LD, BTEU_ST, BTEU_LDA, BTEU_STA,
    BTEU_PMR, BTEU_PMR0, BTEU_PUSH, BTEU_POP
  } bteu_op_t;

  // indirect addressing modes
  typedef enum logic [1:0] {
    BTEU_AM_PLAIN, BTEU_AM_POSTINC, BTEU_AM_PREDEC, BTEU_AM_DISP
  } bteu_amode_t;

  // pointer pair select
  typedef enum logic [1:0] {
    BTEU_PTR_X, BTEU_PTR_Y, BTEU_PTR_Z
  } bteu_ptr_t;

  // ============================================================
  // flag positions in flag_register
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // ============================================================
  // register pair indices (pair number = register index / 2)
  localparam logic [3:0] PAIR_X = 4'hD;
  localparam logic [3:0] PAIR_Y = 4'hE;
  localparam logic [3:0] PAIR_Z = 4'hF;
  localparam logic [4:0] REG_R0 = 5'h00;

  // ============================================================
  // reset values and shared constants
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] SP_RST    = 16'h00FF;
  localparam logic [15:0] ONE16     = 16'h0001;
  localparam logic [7:0]  ONE8      = 8'h01;

endpackage

// ---- hdl/bteu_shift.sv ----
// shift, rotate and swap unit with its flag results
`timescale 1ns/10ps
module bteu_shift (
  // operation
  input  wire bteu_pkg::bteu_op_t op_i,
  input  wire logic [7:0]         din_i,
  input  wire logic               cin_i,
  // result
  output logic [7:0]              dout_o,
  output logic                    cout_o,
  output logic                    z_o,
  output logic                    n_o,
  output logic                    v_o
);
  import bteu_pkg::*;

  // ============================================================
  // per-operation results
  wire [7:0] shl_w  = {din_i[6:0], 1'b0};
  wire [7:0] shr_w  = {1'b0, din_i[7:1]};
  wire [7:0] sar_w  = {din_i[7], din_i[7:1]};
  wire [7:0] rcl_w  = {din_i[6:0], cin_i};
  wire [7:0] rcr_w  = {cin_i, din_i[7:1]};
  wire [7:0] swap_w = {din_i[3:0], din_i[7:4]};
  wire       left_w = (op_i == BTEU_SHL) || (op_i == BTEU_RCL);

  // result select; unknown ops pass the operand through
  assign dout_o = (op_i == BTEU_SHL)  ? shl_w  :
                  (op_i == BTEU_SHR)  ? shr_w  :
                  (op_i == BTEU_SAR)  ? sar_w  :
                  (op_i == BTEU_RCL)  ? rcl_w  :
                  (op_i == BTEU_RCR)  ? rcr_w  :
                  (op_i == BTEU_SWAP) ? swap_w : din_i;

  // bit shifted out lands in carry
  assign cout_o = left_w ? din_i[7] : din_i[0];
  assign z_o    = (dout_o == 8'h00);
  assign n_o    = dout_o[7];
  // overflow after a shift is N xor C
  assign v_o    = n_o ^ cout_o;
endmodule

// ---- tb/bteu_core_monitor.sv ----
// checker of exec unit timing, flag and strobe behaviour
`timescale 1ns/10ps
module bteu_core_monitor
  import bteu_pkg::*;
(
  // clock and reset
  input wire logic               clk_sys_i,
  input wire logic               rstn_i,
  // instruction
  input wire logic               start_i,
  input wire bteu_pkg::bteu_op_t op_i,
  input wire logic [2:0]         bit_i,
  input wire logic [5:0]         io_addr_i,
  input wire logic [7:0]         io_rd_data_i,
  input wire logic               debug_en_i,
  // status and strobes
  input wire logic               busy_o,
  input wire logic               done_o,
  input wire logic [7:0]         flags_o,
  input wire logic [15:0]        sp_o,
  input wire logic [15:0]        dm_addr_o,
  input wire logic               dm_we_o,
  input wire logic               pm_re_o,
  input wire logic [5:0]         io_addr_o,
  input wire logic [7:0]         io_wdata_o,
  input wire logic               io_we_o,
  input wire logic               break_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // ============================================================
  // operation classes, decoded once so the properties stay short
  logic go_w, one_w, two_w, keep_w, shf_w;
  assign go_w   = start_i && !busy_o;
  assign one_w  = op_i inside {BTEU_NOP, BTEU_SLEEP, BTEU_KICK, BTEU_SHL,
                  BTEU_SHR, BTEU_SAR, BTEU_RCL, BTEU_RCR, BTEU_SWAP,
                  BTEU_BSET, BTEU_BCLR, BTEU_TSTO, BTEU_TLDB, BTEU_MOV,
                  BTEU_PCPY, BTEU_LDK, BTEU_IN, BTEU_OUT};
  assign two_w  = op_i inside {BTEU_IOSET, BTEU_IOCLR, BTEU_LD, BTEU_ST,
                  BTEU_LDA, BTEU_STA, BTEU_PUSH, BTEU_POP};
  assign keep_w = two_w || op_i inside {BTEU_SWAP, BTEU_MOV, BTEU_PCPY,
                  BTEU_LDK, BTEU_IN, BTEU_OUT, BTEU_NOP, BTEU_TLDB};
  assign shf_w  = op_i inside {BTEU_SHL, BTEU_SHR, BTEU_SAR, BTEU_RCL,
                  BTEU_RCR};

  // ============================================================
  // timing of each class
  one_cycle_a: assert property (go_w && one_w |=> done_o && !busy_o)
    else $error("single cycle op did not finish in one cycle");
  two_cycle_a: assert property (go_w && two_w |=> busy_o && !done_o ##1 done_o && !busy_o)
    else $error("two cycle op timing wrong");
  pm_read_a: assert property (go_w && op_i inside {BTEU_PMR, BTEU_PMR0} |=> pm_re_o [*2] ##1 done_o)
    else $error("program memory read timing wrong");

  // ============================================================
  // flag effects; shifts must leave S, H, T and I alone
  flags_kept_a: assert property (go_w && keep_w |=> flags_o == $past(flags_o))
    else $error("flags changed by a flag neutral op");
  shift_flags_a: assert property (go_w && shf_w |=> flags_o[FLG_V] == (flags_o[FLG_N] ^ flags_o[FLG_C]) && flags_o[7:4] == $past(flags_o[7:4]))
    else $error("shift flag update wrong");
  flag_set_a: assert property (go_w && op_i == BTEU_BSET |=> flags_o == ($past(flags_o) | (8'h01 << $past(bit_i))))
    else $error("flag set touched other flags");
  flag_clr_a: assert property (go_w && op_i == BTEU_BCLR |=> flags_o == ($past(flags_o) & ~(8'h01 << $past(bit_i))))
    else $error("flag clear touched other flags");

  // ============================================================
  // bus side effects
  push_addr_a: assert property (go_w && op_i == BTEU_PUSH |=> dm_we_o && dm_addr_o == $past(sp_o) && sp_o == $past(sp_o) - 16'h0001)
    else $error("push address or stack pointer wrong");
  out_write_a: assert property (go_w && op_i == BTEU_OUT |=> io_we_o && io_addr_o == $past(io_addr_i))
    else $error("io out write wrong");
  io_set_a: assert property (go_w && op_i == BTEU_IOSET |=> io_wdata_o == ($past(io_rd_data_i) | (8'h01 << $past(bit_i))))
    else $error("io bit set data wrong");
  break_gate_a: assert property (break_o |-> $past(go_w && op_i == BTEU_BRK && debug_en_i))
    else $error("break pulse without debug break op");
endmodule

bind bteu_core bteu_core_monitor u_mon (.clk_sys_i, .rstn_i, .start_i, .op_i,
  .bit_i, .io_addr_i, .io_rd_data_i, .debug_en_i, .busy_o, .done_o, .flags_o,
  .sp_o, .dm_addr_o, .dm_we_o, .pm_re_o, .io_addr_o, .io_wdata_o, .io_we_o,
  .break_o);

// ---- tb/bteu_mem_model.sv ----
// data memory, program memory and io space seen by the exec unit
`timescale 1ns/10ps
module bteu_mem_model (
  // clock
  input  wire logic        clk_sys_i,
  // data memory
  input  wire logic [15:0] dm_addr_i,
  input  wire logic [7:0]  dm_wdata_i,
  input  wire logic        dm_we_i,
  input  wire logic        dm_re_i,
  output logic [7:0]       dm_rdata_o,
  // program memory
  input  wire logic [15:0] pm_addr_i,
  input  wire logic        pm_re_i,
  output logic [7:0]       pm_rdata_o,
  // io space
  input  wire logic [5:0]  io_raddr_i,
  output logic [7:0]       io_rdata_o,
  input  wire logic [5:0]  io_waddr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_we_i
);
  logic [7:0] dm_q [256];
  logic [7:0] io_q [64];
  logic [7:0] dm_last_q = 8'h00;
  logic [7:0] pm_last_q = 8'h00;
  // unread buses show the inverse of the last byte, so stale data cannot pass
  assign dm_rdata_o = dm_re_i ? dm_q[dm_addr_i[7:0]] : ~dm_last_q;
  assign pm_rdata_o = pm_re_i ? (pm_addr_i[7:0] ^ 8'hA5) : ~pm_last_q;
  assign io_rdata_o = io_q[io_raddr_i];
  // writes land at the end of the strobe cycle
  always @(posedge clk_sys_i) begin
    if (dm_we_i) dm_q[dm_addr_i[7:0]] <= dm_wdata_i;
    if (io_we_i) io_q[io_waddr_i] <= io_wdata_i;
    if (dm_re_i) dm_last_q <= dm_rdata_o;
    if (pm_re_i) pm_last_q <= pm_rdata_o;
  end
endmodule

// ---- tb/testbench.sv ----
// self checking testbench of the exec unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin $display("Error %s exp %h got %h", n, e, g); err_total++; end end
module testbench;
  import bteu_pkg::*;
  logic clk_sys_i = 0, rstn_i = 0, start_i = 0, debug_en_i = 0;
  bteu_op_t op_i = BTEU_NOP;
  bteu_amode_t mode_i = BTEU_AM_PLAIN;
  bteu_ptr_t ptr_i = BTEU_PTR_X;
  logic [4:0] rd_i = 0, rr_i = 0, peek_idx_i = 0;
  logic [2:0] bit_i = 0, pls;
  logic [7:0] imm_i = 0, flags_o, peek_data_o, dm_wdata_o, dm_rdata_i;
  logic [7:0] pm_rdata_i, io_rd_data_i, io_wdata_o, v, f0, e;
  logic [15:0] addr_i = 0, sp_o, dm_addr_o, pm_addr_o;
  logic [5:0] io_addr_i = 0, io_addr_o;
  logic busy_o, done_o, dm_we_o, dm_re_o, pm_re_o, io_we_o;
  logic sleep_o, wdt_kick_o, break_o;
  int err_total = 0, checked = 0, cyc;

  // ============================================================
  // design and its memories
  bteu_core u_dut (.clk_sys_i, .rstn_i, .start_i, .op_i, .mode_i, .ptr_i,
    .rd_i, .rr_i, .bit_i, .imm_i, .addr_i, .io_addr_i, .debug_en_i,
    .peek_idx_i, .busy_o, .done_o, .flags_o, .sp_o, .peek_data_o, .dm_addr_o,
    .dm_wdata_o, .dm_we_o, .dm_re_o, .dm_rdata_i, .pm_addr_o, .pm_re_o,
    .pm_rdata_i, .io_rd_data_i, .io_addr_o, .io_wdata_o, .io_we_o, .sleep_o,
    .wdt_kick_o, .break_o);
  bteu_mem_model u_mem (.clk_sys_i, .dm_addr_i(dm_addr_o),
    .dm_wdata_i(dm_wdata_o), .dm_we_i(dm_we_o), .dm_re_i(dm_re_o),
    .dm_rdata_o(dm_rdata_i), .pm_addr_i(pm_addr_o), .pm_re_i(pm_re_o),
    .pm_rdata_o(pm_rdata_i), .io_raddr_i(io_addr_i), .io_rdata_o(io_rd_data_i),
    .io_waddr_i(io_addr_o), .io_wdata_i(io_wdata_o), .io_we_i(io_we_o));

  always #20 clk_sys_i = ~clk_sys_i;

  // ============================================================
  // one instruction: strobes sampled in the cycle after the start edge,
  // extra cycles to done counted, then one spare cycle so results settle
  task go(input bteu_op_t o);
    int n;
    op_i = o;
    start_i = 1;
    @(posedge clk_sys_i);
    #1;
    start_i = 0;
    pls = {sleep_o, wdt_kick_o, break_o};
    n = 0;
    while (done_o !== 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    cyc = n;
    @(posedge clk_sys_i);
    #1;
  endtask
  task peek(input logic [4:0] r);
    peek_idx_i = r;
    @(posedge clk_sys_i);
    #1;
    v = peek_data_o;
  endtask
  task load_k(input logic [4:0] r, input logic [7:0] k);
    rd_i = r;
    imm_i = k;
    go(BTEU_LDK);
  endtask

  // ============================================================
  // shifts, rotates and swap with both carry levels and a zero result
  task s_shift;
    bteu_op_t ops [6];
    logic [7:0] d, r;
    logic c;
    ops = '{BTEU_SHL, BTEU_SHR, BTEU_SAR, BTEU_RCL, BTEU_RCR, BTEU_SWAP};
    for (int i = 0; i < 12; i++) begin
      d = i[0] ? 8'h80 : 8'h4D;
      load_k(16, d);
      bit_i = FLG_C;
      if (i[0]) go(BTEU_BCLR);
      else go(BTEU_BSET);
      f0 = flags_o;
      go(ops[i/2]);
      c = f0[FLG_C];
      case (ops[i/2])
        BTEU_SHL: {c, r} = {d, 1'b0};
        BTEU_SHR: {r, c} = {1'b0, d};
        BTEU_SAR: {r, c} = {d[7], d};
        BTEU_RCL: {c, r} = {d, f0[FLG_C]};
        BTEU_RCR: {r, c} = {f0[FLG_C], d};
        default:  r = {d[3:0], d[7:4]};
      endcase
      e = f0;
      if (ops[i/2] != BTEU_SWAP) e[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
      `CHK("shift flags", e, flags_o);
      `CHK("shift cycles", 0, cyc);
      peek(16);
      `CHK("shift result", r, v);
    end
  endtask

  // every flag set then cleared alone
  task s_flags;
    for (int i = 0; i < 16; i++) begin
      bit_i = i[2:0];
      f0 = flags_o;
      if (i < 8) go(BTEU_BSET);
      else go(BTEU_BCLR);
      e = (i < 8) ? (f0 | (8'h01 << i[2:0])) : (f0 & ~(8'h01 << i[2:0]));
      `CHK("flag op", e, flags_o);
    end
  endtask

  // transfer flag, moves, pair copy
  task s_bit_move;
    load_k(17, 8'h04);
    bit_i = 2;
    go(BTEU_TSTO);
    `CHK("t set", 1'b1, flags_o[FLG_T]);
    load_k(18, 8'h00);
    f0 = flags_o;
    bit_i = 5;
    go(BTEU_TLDB);
    peek(18);
    `CHK("bit load", 8'h20, v);
    load_k(16, 8'h3C);
    rd_i = 19;
    rr_i = 17;
    go(BTEU_MOV);
    peek(19);
    `CHK("move", 8'h04, v);
    rd_i = 20;
    rr_i = 16;
    go(BTEU_PCPY);
    peek(21);
    `CHK("pair copy", 8'h04, v);
    `CHK("move flags", f0, flags_o);
    rd_i = 17;
    bit_i = 3;
    go(BTEU_TSTO);
    `CHK("t clear", 1'b0, flags_o[FLG_T]);
  endtask

  // pointer modes, displacement and direct access
  task s_data;
    load_k(26, 8'h10);
    load_k(27, 8'h00);
    f0 = flags_o;
    rd_i = 17;
    mode_i = BTEU_AM_POSTINC;
    go(BTEU_ST);
    `CHK("st cycles", 1, cyc);
    peek(26);
    `CHK("x after inc", 8'h11, v);
    rd_i = 22;
    mode_i = BTEU_AM_PREDEC;
    go(BTEU_LD);
    peek(22);
    `CHK("ld predec", 8'h04, v);
    load_k(28, 8'h0C);
    load_k(29, 8'h00);
    ptr_i = BTEU_PTR_Y;
    mode_i = BTEU_AM_DISP;
    imm_i = 8'h04;
    rd_i = 16;
    go(BTEU_ST);
    ptr_i = BTEU_PTR_X;
    mode_i = BTEU_AM_PLAIN;
    rd_i = 23;
    go(BTEU_LD);
    peek(23);
    `CHK("disp addr", 8'h3C, v);
    peek(28);
    `CHK("y kept", 8'h0C, v);
    addr_i = 16'h0040;
    rd_i = 18;
    go(BTEU_STA);
    rd_i = 25;
    go(BTEU_LDA);
    `CHK("direct load cycles", 1, cyc);
    peek(25);
    `CHK("direct", 8'h20, v);
    `CHK("data flags", f0, flags_o);
  endtask

  // program memory, io, stack and machine control
  task s_misc;
    load_k(30, 8'h21);
    load_k(31, 8'h00);
    rd_i = 25;
    ptr_i = BTEU_PTR_Z;
    mode_i = BTEU_AM_POSTINC;
    go(BTEU_PMR);
    `CHK("pm read cycles", 2, cyc);
    peek(25);
    `CHK("pm read data", 8'h21 ^ 8'hA5, v);
    mode_i = BTEU_AM_PLAIN;
    go(BTEU_PMR0);
    peek(0);
    `CHK("pm read r0", 8'h22 ^ 8'hA5, v);
    f0 = flags_o;
    io_addr_i = 6'h05;
    rd_i = 16;
    go(BTEU_OUT);
    bit_i = 0;
    go(BTEU_IOSET);
    `CHK("io set cycles", 1, cyc);
    bit_i = 5;
    go(BTEU_IOCLR);
    rd_i = 1;
    go(BTEU_IN);
    `CHK("in cycles", 0, cyc);
    peek(1);
    `CHK("io bits", 8'h1D, v);
    rd_i = 17;
    go(BTEU_PUSH);
    `CHK("sp push", 16'h00FE, sp_o);
    rd_i = 2;
    go(BTEU_POP);
    `CHK("sp pop", 16'h00FF, sp_o);
    peek(2);
    `CHK("pop data", 8'h04, v);
    go(BTEU_SLEEP);
    `CHK("sleep", 3'h4, pls);
    go(BTEU_KICK);
    `CHK("kick", 3'h2, pls);
    go(BTEU_BRK);
    `CHK("brk off", 3'h0, pls);
    debug_en_i = 1;
    go(BTEU_BRK);
    `CHK("brk on", 3'h1, pls);
    `CHK("misc flags", f0, flags_o);
  endtask

  task finish_test;
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ============================================================
  // about 230 cycles of tests; the watchdog allows 10000
  initial begin
    #400000;
    err_total++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1;
    rstn_i = 1;
    `CHK("sp reset", 16'h00FF, sp_o);
    s_shift;
    s_flags;
    s_bit_move;
    s_data;
    s_misc;
    finish_test;
  end
endmodule
